// ==== inc/shutdown_reset_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SHUTDOWN_RESET_MAP_SVH
`define SHUTDOWN_RESET_MAP_SVH
`define SYS_CTRL_ONE_ADDR     8'h03
`define SYS_HIB_CTRL_ADDR     8'h05
`define SYSTEM_ON_BIT         15
`define SW_RESET_BIT          14
`define RESTART_EN_BIT        13
`define HOLD_DUR_HI_BIT       11
`define HOLD_DUR_LO_BIT       10
`define MEM_VALID_BIT         5
`define OFF_HOLD_SEL_BIT      3
`define KEY_POL_BIT           1
`define HIB_REGCLR_SEL_BIT    5
`define HOST_HIB_STATE_BIT    4
`define MEM_HIB_STATE_BIT     2
`define SYS_CTRL_ONE_RESET    16'h0C02
`define SYS_HIB_CTRL_RESET    16'h0000
`define CLK_HZ                50000000
`define MS_TO_CYC(ms)         ((ms) * (`CLK_HZ / 1000))
`define GPIO_OFF_MS           5
`define KEY_OFF_LONG_MS       10000
`define KEY_OFF_SHORT_MS      5000
`define RETRY_INTERVAL_MS     200
`define HOLD_15_MS            15
`define HOLD_30_MS            30
`define HOLD_60_MS            60
`define HOLD_120_MS           120
`define RETRY_LIMIT           8
`define WDOG_FAULT_LIMIT      7
`endif

// ==== inc/shutdown_reset_pkg.sv ====
// Types for the shutdown and reset controller
package shutdown_reset_pkg;
   typedef enum logic [2:0] {ST_OFF, ST_STARTUP, ST_HOLD, ST_ACTIVE, ST_HIBERNATE, ST_RETRY_WAIT} pwr_state_t;
endpackage

// ==== src/shutdown_reset_control.sv ====
// Shutdown, fault restart, register clear and reset output control
`timescale 1ns/100ps
`include "shutdown_reset_map.svh"

module shutdown_reset_control #(
   parameter int unsigned GPIO_OFF_CYC  = `MS_TO_CYC(`GPIO_OFF_MS),
   parameter int unsigned KEY_LONG_CYC  = `MS_TO_CYC(`KEY_OFF_LONG_MS),
   parameter int unsigned KEY_SHORT_CYC = `MS_TO_CYC(`KEY_OFF_SHORT_MS),
   parameter int unsigned RETRY_CYC     = `MS_TO_CYC(`RETRY_INTERVAL_MS),
   parameter int unsigned HOLD_BASE_CYC = `MS_TO_CYC(`HOLD_15_MS)
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        wr_en_i,
   input  wire logic [7:0]  wr_addr_i,
   input  wire logic [15:0] wr_data_i,
   input  wire logic        sec_key_ok_i,
   input  wire logic [7:0]  rd_addr_i,
   output logic      [15:0] rd_data_o,
   input  wire logic        startup_event_i,
   input  wire logic        supplies_good_i,
   input  wire logic        hib_enter_i,
   input  wire logic        hib_exit_i,
   input  wire logic        power_key_i,
   input  wire logic        gpio_power_off_input_i,
   input  wire logic        gpio_power_off_pol_i,
   input  wire logic        manual_reset_n_i,
   input  wire logic        watchdog_timeout_i,
   input  wire logic        thermal_shutdown_i,
   input  wire logic        fault_shutdown_i,
   input  wire logic [1:0]  config_mode_i,
   input  wire logic        crystal_valid_i,
   input  wire logic        dev_mode_off_regclear_i,
   output logic [2:0]       pwr_state_o,
   output logic             host_reset_n_o,
   output logic             host_reset_n_oe_o,
   output logic             gpio_host_reset_n_o,
   output logic             memory_reset_n_o,
   output logic             reg_clear_o,
   output logic             config_request_out_o
);
   // Pin synchronisers
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         sync1_reg <= 6'h00;
         sync2_reg <= 6'h00;
      end
      else
      begin
         sync1_reg <= {power_key_i, gpio_power_off_input_i, manual_reset_n_i,
                       watchdog_timeout_i, thermal_shutdown_i, crystal_valid_i};
         sync2_reg <= sync1_reg;
      end
   end
   wire key_s    = sync2_reg[5];
   wire poff_s   = sync2_reg[4];
   wire mr_n_s   = sync2_reg[3];
   wire wdog_s   = sync2_reg[2];
   wire therm_s  = sync2_reg[1];
   wire xtal_s   = sync2_reg[0];

   shutdown_reset_pkg::pwr_state_t state_reg;
   logic [15:0] ctrl_one_reg;
   logic [15:0] hib_ctrl_reg;
   logic [3:0]  retry_cnt_reg;
   logic [3:0]  fault_cnt_reg;
   logic [31:0] key_cnt_reg;
   logic [31:0] poff_cnt_reg;
   logic [31:0] tmr_reg;
   logic [31:0] swrst_cnt_reg;
   logic        wdog_d_reg;
   logic        powered_once_reg;

   function automatic logic [31:0] hold_cycles(input logic [1:0] code);
      hold_cycles = HOLD_BASE_CYC << code;
   endfunction

   wire [31:0] hold_cyc = hold_cycles(ctrl_one_reg[`HOLD_DUR_HI_BIT:`HOLD_DUR_LO_BIT]);
   wire key_act  = key_s ^ ctrl_one_reg[`KEY_POL_BIT];
   wire poff_act = poff_s ~^ gpio_power_off_pol_i;
   wire [31:0] key_lim = ctrl_one_reg[`OFF_HOLD_SEL_BIT] ? KEY_SHORT_CYC : KEY_LONG_CYC;
   wire wdog_rise = wdog_s && !wdog_d_reg;
   wire on_state = (state_reg == shutdown_reset_pkg::ST_ACTIVE) ||
                   (state_reg == shutdown_reset_pkg::ST_HIBERNATE);
   wire key_done  = key_cnt_reg >= key_lim;
   wire poff_done = poff_cnt_reg >= GPIO_OFF_CYC;
   wire wdog_off  = wdog_rise && (fault_cnt_reg >= 4'(`WDOG_FAULT_LIMIT));
   wire sw_off    = wr_en_i && wr_addr_i == `SYS_CTRL_ONE_ADDR && !wr_data_i[`SYSTEM_ON_BIT];
   wire hard_off  = key_done || poff_done || wdog_off || therm_s || sw_off;
   // Held fault ignored while supplies are down between retries
   wire fault_ev  = fault_shutdown_i && state_reg != shutdown_reset_pkg::ST_OFF &&
                    state_reg != shutdown_reset_pkg::ST_RETRY_WAIT;
   wire regclr_off = !(config_mode_i == 2'b00 && !dev_mode_off_regclear_i);
   wire sw_rst_req = wr_en_i && wr_addr_i == `SYS_CTRL_ONE_ADDR && wr_data_i[`SW_RESET_BIT]
                     && sec_key_ok_i;

   // Hold-time qualification counters
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || !key_act || !on_state)
         key_cnt_reg <= 32'h0;
      else if (!key_done)
         key_cnt_reg <= key_cnt_reg + 32'h1;
   end
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || !poff_act || !on_state)
         poff_cnt_reg <= 32'h0;
      else if (!poff_done)
         poff_cnt_reg <= poff_cnt_reg + 32'h1;
   end

   // Watchdog and fault shutdown history
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         wdog_d_reg    <= 1'b0;
         fault_cnt_reg <= 4'h0;
      end
      else
      begin
         wdog_d_reg <= wdog_s;
         if ((wdog_rise || fault_ev) && fault_cnt_reg != 4'hF)
            fault_cnt_reg <= fault_cnt_reg + 4'h1;
      end
   end

   // Main power state machine
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         state_reg     <= shutdown_reset_pkg::ST_OFF;
         retry_cnt_reg <= 4'h0;
         tmr_reg       <= 32'h0;
      end
      else if (on_state && hard_off)
      begin
         state_reg     <= shutdown_reset_pkg::ST_OFF;
         retry_cnt_reg <= 4'h0;
      end
      else if (fault_ev)
      begin
         tmr_reg <= 32'h0;
         if (ctrl_one_reg[`RESTART_EN_BIT] && retry_cnt_reg < 4'(`RETRY_LIMIT))
         begin
            state_reg     <= shutdown_reset_pkg::ST_RETRY_WAIT;
            retry_cnt_reg <= retry_cnt_reg + 4'h1;
         end
         else
         begin
            state_reg     <= shutdown_reset_pkg::ST_OFF;
            retry_cnt_reg <= 4'h0;
         end
      end
      else
      begin
         case (state_reg)
            shutdown_reset_pkg::ST_OFF:
               if (startup_event_i)
               begin
                  state_reg     <= shutdown_reset_pkg::ST_STARTUP;
                  retry_cnt_reg <= 4'h0;
               end
            shutdown_reset_pkg::ST_RETRY_WAIT:
               if (tmr_reg >= RETRY_CYC - 1)
                  state_reg <= shutdown_reset_pkg::ST_STARTUP;
               else
                  tmr_reg <= tmr_reg + 32'h1;
            shutdown_reset_pkg::ST_STARTUP:
               if (supplies_good_i && (config_mode_i != 2'b11 || xtal_s))
               begin
                  state_reg <= shutdown_reset_pkg::ST_HOLD;
                  tmr_reg   <= 32'h0;
               end
            shutdown_reset_pkg::ST_HOLD:
               if (tmr_reg >= hold_cyc - 1)
               begin
                  state_reg     <= shutdown_reset_pkg::ST_ACTIVE;
                  retry_cnt_reg <= 4'h0;
               end
               else
                  tmr_reg <= tmr_reg + 32'h1;
            shutdown_reset_pkg::ST_ACTIVE:
               if (hib_enter_i)
                  state_reg <= shutdown_reset_pkg::ST_HIBERNATE;
            shutdown_reset_pkg::ST_HIBERNATE:
               if (hib_exit_i)
                  state_reg <= shutdown_reset_pkg::ST_ACTIVE;
            default:
               state_reg <= shutdown_reset_pkg::ST_OFF;
         endcase
      end
   end

   wire entering_off = state_reg != shutdown_reset_pkg::ST_OFF &&
                       ((on_state && hard_off) ||
                        (fault_ev && !(ctrl_one_reg[`RESTART_EN_BIT] && retry_cnt_reg < 4'(`RETRY_LIMIT))));
   wire hib_leave = state_reg == shutdown_reset_pkg::ST_HIBERNATE && hib_exit_i && !hard_off && !fault_ev;
   wire hib_clr   = hib_leave && !hib_ctrl_reg[`HIB_REGCLR_SEL_BIT];
   wire do_clear  = (entering_off && regclr_off) || hib_clr;

   // Software reset hold timer
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         swrst_cnt_reg <= 32'h0;
      else if (sw_rst_req)
         swrst_cnt_reg <= hold_cyc;
      else if (swrst_cnt_reg != 32'h0)
         swrst_cnt_reg <= swrst_cnt_reg - 32'h1;
   end

   // Reset output levels
   logic host_rst_n_next;
   logic mem_rst_n_next;
   always_comb
   begin
      case (state_reg)
         shutdown_reset_pkg::ST_ACTIVE:
         begin
            host_rst_n_next = 1'b1;
            mem_rst_n_next  = 1'b1;
         end
         shutdown_reset_pkg::ST_HIBERNATE:
         begin
            host_rst_n_next = hib_ctrl_reg[`HOST_HIB_STATE_BIT];
            mem_rst_n_next  = hib_ctrl_reg[`MEM_HIB_STATE_BIT];
         end
         default:
         begin
            host_rst_n_next = 1'b0;
            mem_rst_n_next  = 1'b0;
         end
      endcase
      if (!mr_n_s || swrst_cnt_reg != 32'h0 || entering_off)
      begin
         host_rst_n_next = 1'b0;
         mem_rst_n_next  = 1'b0;
      end
   end
   wire mem_rst_sm = !mem_rst_n_next && mr_n_s;

   // Control registers
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || do_clear)
      begin
         ctrl_one_reg <= `SYS_CTRL_ONE_RESET;
         hib_ctrl_reg <= `SYS_HIB_CTRL_RESET;
      end
      else
      begin
         if (wr_en_i && wr_addr_i == `SYS_CTRL_ONE_ADDR)
            ctrl_one_reg <= wr_data_i & 16'hAC2A;
         if (wr_en_i && wr_addr_i == `SYS_HIB_CTRL_ADDR)
            hib_ctrl_reg <= wr_data_i & 16'h0034;
         if (state_reg == shutdown_reset_pkg::ST_STARTUP)
            ctrl_one_reg[`SYSTEM_ON_BIT] <= 1'b1;
         if (state_reg == shutdown_reset_pkg::ST_STARTUP || mem_rst_sm)
            ctrl_one_reg[`MEM_VALID_BIT] <= 1'b0;
         if (state_reg == shutdown_reset_pkg::ST_OFF)
            ctrl_one_reg[`SYSTEM_ON_BIT] <= 1'b0;
      end
   end

   // Registered outputs
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         host_reset_n_o       <= 1'b0;
         host_reset_n_oe_o    <= 1'b1;
         gpio_host_reset_n_o  <= 1'b0;
         memory_reset_n_o     <= 1'b0;
         reg_clear_o          <= 1'b0;
         config_request_out_o <= 1'b0;
         powered_once_reg     <= 1'b0;
         rd_data_o            <= 16'h0000;
         pwr_state_o          <= 3'h0;
      end
      else
      begin
         host_reset_n_o      <= host_rst_n_next;
         host_reset_n_oe_o   <= !host_rst_n_next;
         gpio_host_reset_n_o <= host_rst_n_next;
         memory_reset_n_o    <= mem_rst_n_next;
         reg_clear_o         <= do_clear;
         pwr_state_o         <= 3'(state_reg);
         if (state_reg == shutdown_reset_pkg::ST_STARTUP)
            powered_once_reg <= 1'b1;
         config_request_out_o <= (state_reg == shutdown_reset_pkg::ST_STARTUP) ||
                                 (powered_once_reg && !regclr_off);
         case (rd_addr_i)
            `SYS_CTRL_ONE_ADDR: rd_data_o <= ctrl_one_reg;
            `SYS_HIB_CTRL_ADDR: rd_data_o <= hib_ctrl_reg;
            default:            rd_data_o <= 16'h0000;
         endcase
      end
   end

   // Checks
   off_host_low_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      state_reg == shutdown_reset_pkg::ST_OFF |=> !host_reset_n_o)
      else $error("host reset high in off");
   hard_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      on_state && hard_off |=> state_reg == shutdown_reset_pkg::ST_OFF)
      else $error("shutdown event ignored");
   mr_resets_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      !mr_n_s |=> !host_reset_n_o && !memory_reset_n_o)
      else $error("manual reset not applied");
   no_restart_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      fault_ev && !ctrl_one_reg[`RESTART_EN_BIT] && !(on_state && hard_off)
      |=> state_reg == shutdown_reset_pkg::ST_OFF)
      else $error("fault without restart not off");
   retry_bound_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      retry_cnt_reg <= 4'(`RETRY_LIMIT))
      else $error("retry count over limit");
   sysrst_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      sw_rst_req |=> ##1 !host_reset_n_o [*2])
      else $error("software reset not held");
   startup_on_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      state_reg == shutdown_reset_pkg::ST_STARTUP && !do_clear |=> ctrl_one_reg[`SYSTEM_ON_BIT])
      else $error("system-on not set in start-up");
   hib_host_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      state_reg == shutdown_reset_pkg::ST_HIBERNATE && mr_n_s && swrst_cnt_reg == 32'h0 && !entering_off
      |=> host_reset_n_o == $past(hib_ctrl_reg[`HOST_HIB_STATE_BIT]))
      else $error("hibernate host reset level wrong");
   mem_valid_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      mem_rst_sm |=> !ctrl_one_reg[`MEM_VALID_BIT])
      else $error("memory valid not cleared");
   xtal_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      state_reg == shutdown_reset_pkg::ST_STARTUP && config_mode_i == 2'b11 && !xtal_s && !fault_ev
      |=> state_reg == shutdown_reset_pkg::ST_STARTUP)
      else $error("start-up passed without crystal");
   reach_active_c: cover property (@(posedge mclk_i) state_reg == shutdown_reset_pkg::ST_ACTIVE);
   retry_c: cover property (@(posedge mclk_i) state_reg == shutdown_reset_pkg::ST_RETRY_WAIT);
   wdog_early_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      on_state && wdog_rise && fault_cnt_reg < 4'(`WDOG_FAULT_LIMIT) && !key_done && !poff_done
      && !therm_s && !sw_off && !fault_ev |=> state_reg != shutdown_reset_pkg::ST_OFF)
      else $error("watchdog shutdown too early");
   hib_clr_c: cover property (@(posedge mclk_i) hib_clr);
   wdog_off_c: cover property (@(posedge mclk_i) on_state && wdog_off);
   keep_regs_c: cover property (@(posedge mclk_i) entering_off && !regclr_off);
endmodule // shutdown_reset_control

// ==== dv/host_model.sv ====
// Host processor model: keyed register writes and registered reads
`timescale 1ns/100ps
module host_model (
   input  wire logic        mclk_i,
   input  wire logic [15:0] rd_data_i,
   output logic             wr_en_o,
   output logic [7:0]       wr_addr_o,
   output logic [15:0]      wr_data_o,
   output logic             sec_key_ok_o,
   output logic [7:0]       rd_addr_o
);
   initial
   begin
      wr_en_o = 1'b0;
      wr_addr_o = 8'h00;
      wr_data_o = 16'h0000;
      sec_key_ok_o = 1'b0;
      rd_addr_o = 8'h00;
   end
   // Whole word and address in one strobe cycle, then lines scrambled
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic k);
      @(posedge mclk_i);
      wr_en_o <= 1'b1;
      wr_addr_o <= a;
      wr_data_o <= d;
      sec_key_ok_o <= k;
      @(posedge mclk_i);
      wr_en_o <= 1'b0;
      wr_addr_o <= ~a;
      wr_data_o <= ~d;
      sec_key_ok_o <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      rd_addr_o <= a;
      @(posedge mclk_i);
      @(negedge mclk_i);
      d = rd_data_i;
   endtask
endmodule // host_model

// ==== dv/shutdown_reset_control_tb_top.sv ====
// Self-checking bench for the shutdown and reset controller
`timescale 1ns/100ps
module shutdown_reset_control_tb_top;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wr_en, sec_key, hrn, hoe, ghrn, mrst, rclr, cfg;
   logic        se = 1'b0, hen = 1'b0, hex = 1'b0, key = 1'b1, gpo = 1'b0;
   logic        mrn = 1'b1, ths = 1'b0, flt = 1'b0, xtal = 1'b0;
   logic        sg = 1'b1, gpol = 1'b1, wdog = 1'b0, devclr = 1'b1;
   logic [1:0]  cmode = 2'b11;
   logic [7:0]  wr_addr, rd_addr;
   logic [15:0] wr_data, rd_data, d;
   logic [2:0]  st, st_q;
   int          errors = 0, check_count = 0, retries = 0, clears = 0, n, c0, r0;
   int          lo[5] = '{0, 20, 0, 50, 0};
   int          hi[5] = '{4, 26, 6, 58, 4};

   shutdown_reset_control #(.GPIO_OFF_CYC(20), .KEY_LONG_CYC(100), .KEY_SHORT_CYC(50),
      .RETRY_CYC(40), .HOLD_BASE_CYC(10)) shutdown_reset_control_inst (
      .mclk_i(mclk_i), .rst_i(rst_i), .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
      .sec_key_ok_i(sec_key), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .startup_event_i(se),
      .supplies_good_i(sg), .hib_enter_i(hen), .hib_exit_i(hex), .power_key_i(key),
      .gpio_power_off_input_i(gpo), .gpio_power_off_pol_i(gpol), .manual_reset_n_i(mrn),
      .watchdog_timeout_i(wdog), .thermal_shutdown_i(ths), .fault_shutdown_i(flt),
      .config_mode_i(cmode), .crystal_valid_i(xtal), .dev_mode_off_regclear_i(devclr),
      .pwr_state_o(st), .host_reset_n_o(hrn), .host_reset_n_oe_o(hoe), .gpio_host_reset_n_o(ghrn),
      .memory_reset_n_o(mrst), .reg_clear_o(rclr), .config_request_out_o(cfg));

   host_model host_model_inst (.mclk_i(mclk_i), .rd_data_i(rd_data), .wr_en_o(wr_en),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data), .sec_key_ok_o(sec_key), .rd_addr_o(rd_addr));

   initial
   begin
      forever #10 mclk_i = ~mclk_i;
   end

   // Retry entries and register clears seen
   always @(posedge mclk_i)
   begin
      st_q <= st;
      if (st === 3'd5 && st_q !== 3'd5) retries++;
      if (rclr === 1'b1) clears++;
   end

   initial
   begin
      repeat (10000) @(posedge mclk_i);
      errors++;
      end_sim();
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_rng(input string nm, input int l, input int h, input int g);
      check_count++;
      if (g < l || g > h)
      begin
         errors++;
         $display("BAD %s expected %0d..%0d seen %0d", nm, l, h, g);
      end
   endtask
   task automatic wait_st(input logic [2:0] s, input int lim, output int k);
      k = 0;
      while (st !== s && k < lim)
      begin
         @(negedge mclk_i);
         k++;
      end
   endtask
   task automatic count_low(output int k);
      wait_st(st, 10, k);
      k = 0;
      while (hrn !== 1'b0 && k < 10)
      begin
         @(negedge mclk_i);
         k++;
      end
      k = 0;
      while (hrn === 1'b0 && k < 3000)
      begin
         @(negedge mclk_i);
         k++;
      end
   endtask
   task automatic bring_up();
      @(posedge mclk_i);
      xtal <= 1'b0;
      sg <= 1'b0;
      se <= 1'b1;
      @(posedge mclk_i);
      se <= 1'b0;
      repeat (50) @(negedge mclk_i);
      chk("crystal wait", 16'h0002, {12'h0, st, hrn});
      @(posedge mclk_i);
      xtal <= 1'b1;
      repeat (10) @(negedge mclk_i);
      chk("supply wait", 16'h0002, {12'h0, st, hrn});
      @(posedge mclk_i);
      sg <= 1'b1;
      wait_st(3'd2, 20, n);
      count_low(n);
      chk_rng("hold cycles", 80, 82, n);
      wait_st(3'd3, 10, n);
      chk("gpio copy", 16'h0001, {15'h0, ghrn});
      host_model_inst.rd(8'h03, d);
      chk("system on", 16'h0001, {15'h0, d[15]});
      chk("mem valid", 16'h0000, {15'h0, d[5]});
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      host_model_inst.rd(8'h03, d);
      chk("ctrl reset", 16'h0C02, d);
      host_model_inst.rd(8'h05, d);
      chk("hib reset", 16'h0000, d);
      host_model_inst.rd(8'h07, d);
      chk("unmapped", 16'h0000, d);
      chk("off reset", 16'h0001, {14'h0, hrn, hoe});
      bring_up();
      $display("test startup done");
      @(posedge mclk_i);
      wdog <= 1'b1;
      repeat (8) @(negedge mclk_i);
      chk("early wdog", 16'h0003, {13'h0, st});
      @(posedge mclk_i);
      wdog <= 1'b0;
      host_model_inst.wr(8'h03, 16'h8022, 1'b0);
      host_model_inst.wr(8'h03, 16'hC022, 1'b0);
      repeat (5) @(negedge mclk_i);
      chk("unkeyed", 16'h0003, {14'h0, hrn, mrst});
      host_model_inst.rd(8'h03, d);
      chk("ctrl read", 16'h8022, d);
      host_model_inst.wr(8'h03, 16'hC022, 1'b1);
      count_low(n);
      chk_rng("sw reset", 10, 12, n);
      $display("test software reset done");
      @(posedge mclk_i);
      mrn <= 1'b0;
      repeat (5) @(negedge mclk_i);
      chk("manual", 16'h000C, {11'h0, st, hrn, mrst});
      @(posedge mclk_i);
      mrn <= 1'b1;
      repeat (5) @(negedge mclk_i);
      chk("manual off", 16'h000F, {11'h0, st, hrn, mrst});
      host_model_inst.wr(8'h05, 16'h0010, 1'b0);
      @(posedge mclk_i);
      hen <= 1'b1;
      wait_st(3'd4, 50, n);
      repeat (3) @(negedge mclk_i);
      chk("hib pins", 16'h0012, {11'h0, st, hrn, mrst});
      c0 = clears;
      @(posedge mclk_i);
      hen <= 1'b0;
      hex <= 1'b1;
      wait_st(3'd3, 500, n);
      @(posedge mclk_i);
      hex <= 1'b0;
      chk_rng("hib clear", c0 + 1, c0 + 3, clears);
      host_model_inst.rd(8'h05, d);
      chk("hib cleared", 16'h0000, d);
      count_low(n);
      $display("test hibernate done");
      @(posedge mclk_i);
      key <= 1'b0;
      repeat (30) @(posedge mclk_i);
      key <= 1'b1;
      repeat (10) @(negedge mclk_i);
      chk("short key", 16'h0003, {13'h0, st});
      for (int k = 0; k < 5; k++)
      begin
         if (k > 0) bring_up();
         c0 = clears;
         r0 = retries;
         @(posedge mclk_i);
         case (k)
            0: host_model_inst.wr(8'h03, 16'h0C02, 1'b0);
            1: gpo <= 1'b1;
            2: ths <= 1'b1;
            3: host_model_inst.wr(8'h03, 16'h8C08, 1'b0);
            default: flt <= 1'b1;
         endcase
         wait_st(3'd0, 200, n);
         chk_rng("off time", lo[k], hi[k], n);
         @(posedge mclk_i);
         gpo <= 1'b0;
         ths <= 1'b0;
         flt <= 1'b0;
         repeat (3) @(negedge mclk_i);
         chk("off pins", 16'h0000, {11'h0, st, hrn, mrst});
         chk_rng("off clear", c0 + 1, c0 + 3, clears);
         host_model_inst.rd(8'h03, d);
         chk("off regs", 16'h0C02, d);
         chk_rng("no retry", r0, r0, retries);
      end
      $display("test shutdown events done");
      bring_up();
      host_model_inst.wr(8'h03, 16'hAC02, 1'b0);
      r0 = retries;
      @(posedge mclk_i);
      flt <= 1'b1;
      wait_st(3'd0, 3000, n);
      @(posedge mclk_i);
      flt <= 1'b0;
      chk_rng("retries", r0 + 8, r0 + 8, retries);
      bring_up();
      host_model_inst.wr(8'h03, 16'hAC02, 1'b0);
      @(posedge mclk_i);
      flt <= 1'b1;
      @(posedge mclk_i);
      flt <= 1'b0;
      wait_st(3'd5, 20, n);
      chk("retry again", 16'h0005, {13'h0, st});
      $display("test fault restart done");
      wait_st(3'h3, 300, n);
      @(posedge mclk_i);
      wdog <= 1'b1;
      wait_st(3'h0, 20, n);
      chk_rng("wdog off", 0, 6, n);
      @(posedge mclk_i);
      wdog <= 1'b0;
      cmode <= 2'b00;
      devclr <= 1'b0;
      c0 = clears;
      se <= 1'b1;
      @(posedge mclk_i);
      se <= 1'b0;
      wait_st(3'h3, 200, n);
      chk("dev conf on", 16'h0001, {15'h0, cfg});
      host_model_inst.wr(8'h03, 16'h0C0A, 1'b0);
      wait_st(3'h0, 20, n);
      repeat (3) @(negedge mclk_i);
      chk_rng("dev no clear", c0, c0, clears);
      chk("dev conf off", 16'h0001, {15'h0, cfg});
      host_model_inst.rd(8'h03, d);
      chk("dev regs kept", 16'h0C0A, d);
      $display("test watchdog and dev mode done");
      end_sim();
   end
endmodule // shutdown_reset_control_tb_top
